// ### verilog/autoneg_ctrl.sv
// Auto-negotiation, crossover and downshift control with its register file
`timescale 1ns/10ps
// Overview of operation
// - Bits 10 and 11 of advertisement register put pause abilities in base page.
// - Partner pause abilities land in bits 10 and 11 of partner register.
// - Pause bits go out only when a full-duplex mode is advertised.
// - Next pages are sent from the next-page transmit register.
// - 10/100 receiver link status feeds parallel detection of the technology.
// - Parallel detection sets partner bit 5 or 7 for the detected mode.
// - Parallel detection loads selector field with 00001.
// - Expansion bit 0 reads 0 after completion by parallel detection.
// - Parallel detection with no clean link sets expansion fault bit 4.
// - Losing a negotiated link restarts negotiation.
// - Writing 1 to control bit 9 restarts negotiation.
// - A restart silences transmit until break-link timer ends, then FLPs.
// - Strap-disabled negotiation cannot be enabled by a register write.
// - Cable crossing is resolved and pairs mapped before FLP exchange.
// - Auto crossover follows strap or phy_control bit 6.
// - Without auto crossover, strap or phy_control bit 5 forces mapping.
// - Crossover resolution runs in negotiated and forced speed modes.
// - Downshift falls to 100M after the set count of gigabit failures.
// - Downshift falls to 10M after further failures at 100M.
// - Downshift acts only when enabled in phy_control.
// - The highest common speed and duplex within the downshift speed ceiling wins.
module autoneg_ctrl #(
  parameter int BREAK_CYCLES   = 1000,
  parameter int ATTEMPT_CYCLES = 4000
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [15:0]       reg_rdata,
  input  wire logic              strap_an_off,
  input  wire logic              crossover_auto_off_strap,
  input  wire logic              crossover_force_strap,
  input  wire logic              rx_page_valid,
  input  wire logic [15:0]       rx_page,
  input  wire logic              lp_gig_able,
  input  wire logic              link_10_pd,
  input  wire logic              link_100_pd,
  input  wire logic              link_good,
  input  wire logic              cable_crossed,
  output logic      [15:0]       tx_page,
  output logic                   tx_flp_en,
  output logic                   tx_halt,
  output an_pkg::speed_type      speed,
  output logic                   full_duplex,
  output logic                   pair_swap_ab,
  output logic                   pair_swap_cd,
  output logic                   an_complete
);
  import an_pkg::*;

  typedef enum logic [2:0] {st_off, st_break, st_detect, st_np, st_wait, st_up} state_type;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  state_type   state_q, state_d;
  logic [15:0] bc_q, ad_q, lp_q, np_q, pc_q;
  logic [15:0] timer_q;
  logic [2:0]  sync1_q, sync2_q, strap_q;
  logic [1:0]  settle_q;
  logic        lp_able_q, page_rx_q, pd_fault_q, pd_done_q, mdix_q;
  speed_type   spd_q, cap;
  logic        fd_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire cap_now   = settle_q == STRAP_SETTLE;
  wire an_off_st = cap_now ? sync2_q[0] : strap_q[0];
  wire wr_bc     = reg_we && reg_addr == REG_BASIC_CONTROL;
  wire wr_ad     = reg_we && reg_addr == REG_ADVERTISE;
  wire wr_np     = reg_we && reg_addr == REG_NP_TRANSMIT;
  wire wr_pc     = reg_we && reg_addr == REG_PHY_CONTROL;
  wire rd_ex     = reg_re && reg_addr == REG_EXPANSION;
  wire an_en     = bc_q[BC_AN_EN];
  wire restart   = wr_bc && reg_wdata[BC_RESTART] && an_en;
  wire in_detect = state_q == st_detect;
  wire page_in   = in_detect && rx_page_valid;
  wire np_both   = ad_q[AD_NP] && rx_page[AD_NP];
  wire np_last   = !np_q[AD_NP] && !rx_page[AD_NP];
  wire pd_one    = link_10_pd ^ link_100_pd;
  wire pd_ok     = in_detect && !rx_page_valid && pd_one;
  wire pd_bad    = in_detect && !rx_page_valid && link_10_pd && link_100_pd;
  wire ad_fd     = ad_q[AD_10FD] || ad_q[AD_100FD];
  wire timer_end = timer_q == (state_q == st_break ? 16'(BREAK_CYCLES - 1)
                                                   : 16'(ATTEMPT_CYCLES - 1));
  wire break_end = state_q == st_break && timer_end;
  wire try_fail  = state_q == st_wait && !link_good && timer_end;
  wire try_ok    = state_q == st_wait && link_good;
  wire resolve   = (page_in && !np_both) ||
                   (state_q == st_np && rx_page_valid && np_last);
  wire [15:0] lp_src = in_detect ? rx_page : lp_q;
  wire [15:0] common = ad_q & lp_src;
  wire go_gig    = lp_gig_able && cap == spd_1000;
  wire go_100    = (common[AD_100FD] || common[AD_100HD]) && cap != spd_10;
  wire [15:0] pd_page = {8'h00, link_100_pd, 1'b0, link_10_pd, SELECTOR_8023};
  wire [15:0] ad_tx   = ad_fd ? ad_q : (ad_q & ~(16'h0001 << AD_PAUSE)
                                             & ~(16'h0001 << AD_ASYM));
  wire auto_x    = pc_q[PC_AMDIX_EN];
  wire [1:0] bc_spd = {bc_q[BC_SPD_MSB], bc_q[BC_SPD_LSB]};

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q  <= 3'h0;
      sync2_q  <= 3'h0;
      strap_q  <= 3'h0;
      settle_q <= 2'h0;
    end else begin
      sync1_q <= {crossover_force_strap, crossover_auto_off_strap, strap_an_off};
      sync2_q <= sync1_q;
      if (settle_q != STRAP_SETTLE + 2'h1) begin
        settle_q <= settle_q + 2'h1;
      end
      if (cap_now) begin
        strap_q <= sync2_q;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bc_q <= BC_RESET;
      ad_q <= AD_RESET;
      np_q <= NP_RESET;
      pc_q <= PC_RESET;
    end else begin
      if (wr_bc) begin
        bc_q <= reg_wdata & ~(16'h0001 << BC_RESTART);
      end
      if (an_off_st) begin
        bc_q[BC_AN_EN] <= 1'b0;
      end
      if (wr_ad) begin
        ad_q <= reg_wdata;
      end
      if (wr_np) begin
        np_q <= reg_wdata;
      end
      if (wr_pc) begin
        pc_q <= reg_wdata;
      end else if (cap_now) begin
        pc_q[PC_AMDIX_EN] <= !sync2_q[1];
        pc_q[PC_FORCE_X]  <= sync2_q[2];
      end
    end
  end

  // ----------------------------------------
  // Negotiation sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_off:    if (an_en) state_d = st_break;
      st_break:  if (timer_end) state_d = st_detect;
      st_detect: begin
        if (rx_page_valid) begin
          state_d = np_both ? st_np : st_wait;
        end else if (pd_one) begin
          state_d = st_up;
        end
      end
      st_np:     if (rx_page_valid && np_last) state_d = st_wait;
      st_wait: begin
        if (link_good) begin
          state_d = st_up;
        end else if (timer_end) begin
          state_d = st_break;
        end
      end
      st_up:     if (!link_good) state_d = st_break;
    endcase
    if (!an_en) begin
      state_d = st_off;
    end else if (restart) begin
      state_d = st_break;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= st_off;
      timer_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? 16'h0000 : timer_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Partner page and expansion flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lp_q       <= 16'h0000;
      lp_able_q  <= 1'b0;
      page_rx_q  <= 1'b0;
      pd_fault_q <= 1'b0;
      pd_done_q  <= 1'b0;
    end else begin
      if (page_in) begin
        lp_q      <= rx_page;
        lp_able_q <= 1'b1;
      end else if (pd_ok) begin
        lp_q      <= pd_page;
        pd_done_q <= 1'b1;
      end else if (state_q == st_off || break_end) begin
        lp_able_q <= 1'b0;
        pd_done_q <= 1'b0;
      end
      page_rx_q  <= rx_page_valid || (page_rx_q && !rd_ex);
      pd_fault_q <= pd_bad || (pd_fault_q && !rd_ex);
    end
  end

  // ----------------------------------------
  // Resolution and crossover
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spd_q  <= spd_10;
      fd_q   <= 1'b0;
      mdix_q <= 1'b0;
    end else begin
      if (resolve) begin
        spd_q <= go_gig ? spd_1000 : (go_100 ? spd_100 : spd_10);
        fd_q  <= go_gig || (go_100 ? common[AD_100FD] : common[AD_10FD]);
      end else if (pd_ok) begin
        spd_q <= link_100_pd ? spd_100 : spd_10;
        fd_q  <= 1'b0;
      end else if (state_q == st_off) begin
        spd_q <= bc_spd == 2'h2 ? spd_1000 : (bc_spd == 2'h1 ? spd_100 : spd_10);
        fd_q  <= bc_q[BC_DUPLEX];
      end
      if (break_end || state_q == st_off) begin
        mdix_q <= cable_crossed;
      end
    end
  end

  downshift_ctrl u_downshift (
    .clk          (clk),
    .rst          (rst),
    .enable       (pc_q[PC_DS_EN]),
    .limit        (pc_q[PC_DS_MSB:PC_DS_LSB]),
    .attempt_fail (try_fail),
    .attempt_ok   (try_ok),
    .tried        (spd_q),
    .cap          (cap)
  );

  // ----------------------------------------
  // Outputs and register read
  // ----------------------------------------
  wire [15:0] bs_val = {10'h000, an_complete, 1'b0, 1'b1, state_q == st_up, 2'h0};
  wire [15:0] ex_val = {11'h000, pd_fault_q, 2'h0, page_rx_q, lp_able_q};
  wire [15:0] rd_mux =
    reg_addr == REG_BASIC_CONTROL ? bc_q :
    reg_addr == REG_BASIC_STATUS  ? bs_val :
    reg_addr == REG_ADVERTISE     ? ad_q :
    reg_addr == REG_PARTNER       ? lp_q :
    reg_addr == REG_EXPANSION     ? ex_val :
    reg_addr == REG_NP_TRANSMIT   ? np_q :
    reg_addr == REG_PHY_CONTROL   ? pc_q : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      tx_page   <= 16'h0000;
    end else begin
      if (reg_re) begin
        reg_rdata <= rd_mux;
      end
      tx_page <= (state_d == st_np) ? np_q : ad_tx;
    end
  end

  assign tx_flp_en    = in_detect || state_q == st_np;
  assign tx_halt      = state_q == st_break;
  assign speed        = spd_q;
  assign full_duplex  = fd_q;
  assign an_complete  = state_q == st_wait || state_q == st_up;
  assign pair_swap_ab = auto_x ? mdix_q : pc_q[PC_FORCE_X];
  assign pair_swap_cd = pair_swap_ab && spd_q == spd_1000;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_restart_break: assert property (restart |=> state_q == st_break)
    else $error("restart did not break link");
  chk_break_quiet: assert property (state_q == st_break |-> tx_halt && !tx_flp_en)
    else $error("activity during break");
  chk_strap_lock: assert property (strap_q[0] |-> !bc_q[BC_AN_EN])
    else $error("negotiation enabled against strap");
  chk_pd_selector: assert property (pd_ok |=> lp_q[4:0] == SELECTOR_8023 && state_q == st_up)
    else $error("parallel detect page wrong");
  chk_pd_mode: assert property (pd_ok && link_100_pd |=> lp_q[AD_100HD] && !lp_able_q)
    else $error("parallel detect mode bits wrong");
  chk_pd_fault: assert property (pd_bad |=> pd_fault_q)
    else $error("parallel detect fault missed");
  chk_link_loss: assert property (state_q == st_up && !link_good && an_en && !restart
    |=> state_q == st_break ##1 tx_halt) else $error("lost link not restarted");
  chk_force_map: assert property (!auto_x |-> pair_swap_ab == pc_q[PC_FORCE_X])
    else $error("forced mapping ignored");
  chk_pause_adv: assert property (in_detect && ad_fd && $stable(ad_q)
    |-> tx_page[11:10] == ad_q[AD_ASYM:AD_PAUSE]) else $error("pause not sent");
  chk_partner_keep: assert property (page_in |=> lp_q == $past(rx_page))
    else $error("partner page not stored");

  cov_negotiated: cover property (resolve ##[1:20] state_q == st_up);
  cov_parallel: cover property (pd_ok);
  cov_next_page: cover property (state_q == st_np ##[1:50] state_q == st_wait);
endmodule

// ### verilog/an_pkg.sv
// Register map, field positions and types for the auto-negotiation controller
package an_pkg;
  localparam int         AW                = 5;
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS  = 5'h01;
  localparam logic [4:0] REG_ADVERTISE     = 5'h04;
  localparam logic [4:0] REG_PARTNER       = 5'h05;
  localparam logic [4:0] REG_EXPANSION     = 5'h06;
  localparam logic [4:0] REG_NP_TRANSMIT   = 5'h07;
  localparam logic [4:0] REG_PHY_CONTROL   = 5'h10;

  // basic_control fields
  localparam int BC_SPD_MSB = 6;
  localparam int BC_DUPLEX  = 8;
  localparam int BC_RESTART = 9;
  localparam int BC_AN_EN   = 12;
  localparam int BC_SPD_LSB = 13;
  // basic_status fields
  localparam int BS_LINK     = 2;
  localparam int BS_AN_ABLE  = 3;
  localparam int BS_COMPLETE = 5;
  // advertisement / partner ability fields
  localparam int AD_10FD  = 6;
  localparam int AD_100HD = 7;
  localparam int AD_100FD = 8;
  localparam int AD_PAUSE = 10;
  localparam int AD_ASYM  = 11;
  localparam int AD_NP    = 15;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  // negotiation_expansion fields
  localparam int EX_LP_ABLE  = 0;
  localparam int EX_PAGE_RX  = 1;
  localparam int EX_PD_FAULT = 4;
  // phy_control fields
  localparam int PC_FORCE_X  = 5;
  localparam int PC_AMDIX_EN = 6;
  localparam int PC_DS_EN    = 11;
  localparam int PC_DS_LSB   = 12;
  localparam int PC_DS_MSB   = 14;

  localparam logic [15:0] BC_RESET = 16'h1140;
  localparam logic [15:0] AD_RESET = 16'h01E1;
  localparam logic [15:0] NP_RESET = 16'h2001;
  localparam logic [15:0] PC_RESET = 16'h4040;
  localparam logic [1:0]  STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {spd_10, spd_100, spd_1000} speed_type;
endpackage

// ### verilog/downshift_ctrl.sv
// Failed-attempt counter and speed ceiling for link downshift
`timescale 1ns/10ps
module downshift_ctrl (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire logic [2:0]        limit,
  input  wire logic              attempt_fail,
  input  wire logic              attempt_ok,
  input  wire an_pkg::speed_type tried,
  output an_pkg::speed_type      cap
);
  import an_pkg::*;

  logic [2:0] fails_q;
  speed_type  cap_q;
  wire        hit = ({1'b0, fails_q} + 4'h1) >= {1'b0, limit};

  assign cap = cap_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fails_q <= 3'h0;
      cap_q   <= spd_1000;
    end else if (!enable) begin
      fails_q <= 3'h0;
      cap_q   <= spd_1000;
    end else if (attempt_ok) begin
      fails_q <= 3'h0;
    end else if (attempt_fail) begin
      if (hit) begin
        fails_q <= 3'h0;
        if (tried == spd_1000) begin
          cap_q <= spd_100;
        end else if (tried == spd_100) begin
          cap_q <= spd_10;
        end
      end else begin
        fails_q <= fails_q + 3'h1;
      end
    end
  end

  chk_ds_off_full: assert property (@(posedge clk) disable iff (rst)
    !enable |=> cap_q == spd_1000) else $error("downshift active while off");
endmodule

// ### bench/link_partner_model.sv
// Behavioural link partner on the far side of the twisted pair
`timescale 1ns/10ps
module link_partner_model (
  input  wire logic        clk,
  input  wire logic        tx_flp_en,
  input  wire logic        tx_halt,
  input  wire logic        an_complete,
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] page,
  input  wire logic        link_ok,
  input  wire logic        gig,
  input  wire logic        crossed,
  input  wire logic [3:0]  dly,
  output logic             rx_page_valid,
  output logic      [15:0] rx_page,
  output logic             lp_gig_able,
  output logic             link_10_pd,
  output logic             link_100_pd,
  output logic             link_good,
  output logic             cable_crossed
);
  // ------------------------------------------------------------
  // Modes: 0 quiet, 1 negotiating, 2 legacy 10, 3 legacy 100, 4 both
  // ------------------------------------------------------------
  int gap = 0;
  initial begin
    {rx_page_valid, rx_page, lp_gig_able, link_10_pd, link_100_pd, link_good} = '0;
    cable_crossed = 1'b0;
  end
  always @(negedge clk) begin
    lp_gig_able <= gig;
    cable_crossed <= crossed;
    link_10_pd <= !tx_halt && (mode == 3'h2 || mode == 3'h4);
    link_100_pd <= !tx_halt && (mode == 3'h3 || mode == 3'h4);
    link_good <= !tx_halt && link_ok && (an_complete || link_good);
    rx_page_valid <= 1'b0;
    // Released page lines do not hold the last word
    rx_page <= ~rx_page;
    if (tx_flp_en && mode == 3'h1) begin
      gap <= (gap == dly + 3) ? 0 : gap + 1;
      if (gap == dly) begin
        rx_page_valid <= 1'b1;
        rx_page <= page;
      end
    end else begin
      gap <= 0;
    end
  end
endmodule

// ### bench/autoneg_mdix_downshift_ctrl_tb.sv
// Self-checking bench for the auto-negotiation controller
`timescale 1ns/10ps
module autoneg_mdix_downshift_ctrl_tb;
  import an_pkg::*;
  localparam int BRK = 8;
  logic        clk, rst, we, re, s_an, s_ax, s_fx, p_ok, p_gig, p_x;
  logic        rpv, lgig, l10, l100, lgood, xc, flp, halt, fd, sab, scd, done;
  logic [2:0]  p_mode;
  logic [3:0]  p_dly;
  logic [4:0]  addr;
  logic [15:0] wd, rd, txp, rpg, p_page, v, adv, np;
  speed_type   spd, cap;
  int          fail_count, compares, n, cnt;
  int          plan[$] = '{1, 0, 1, 0, 0, 0, 0, 0};
  logic [4:0]  ra[5] = '{REG_BASIC_CONTROL, REG_ADVERTISE, REG_NP_TRANSMIT, REG_PHY_CONTROL, 5'h02};
  logic [15:0] rv[5] = '{BC_RESET, AD_RESET, NP_RESET, PC_RESET, 16'h0000};
  // ------------------------------------------------------------
  // Design and partner
  // ------------------------------------------------------------
  autoneg_ctrl #(.BREAK_CYCLES(BRK), .ATTEMPT_CYCLES(16)) autoneg_ctrl_inst (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re),
    .reg_rdata(rd), .strap_an_off(s_an), .crossover_auto_off_strap(s_ax),
    .crossover_force_strap(s_fx), .rx_page_valid(rpv), .rx_page(rpg), .lp_gig_able(lgig),
    .link_10_pd(l10), .link_100_pd(l100), .link_good(lgood), .cable_crossed(xc),
    .tx_page(txp), .tx_flp_en(flp), .tx_halt(halt), .speed(spd), .full_duplex(fd),
    .pair_swap_ab(sab), .pair_swap_cd(scd), .an_complete(done));
  link_partner_model link_partner_model_inst (
    .clk(clk), .tx_flp_en(flp), .tx_halt(halt), .an_complete(done), .mode(p_mode),
    .page(p_page), .link_ok(p_ok), .gig(p_gig), .crossed(p_x), .dly(p_dly),
    .rx_page_valid(rpv), .rx_page(rpg), .lp_gig_able(lgig), .link_10_pd(l10),
    .link_100_pd(l100), .link_good(lgood), .cable_crossed(xc));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    d = rd;
  endtask
  // Select: 0 complete, 1 pulses, 2 link, 3 halt
  task automatic wait_hi(input int sel);
    logic [3:0] s;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      s = {halt, lgood, flp, done};
      if (s[sel] === 1'b1) break;
    end
  endtask
  task automatic do_reset(input logic an, input logic ax, input logic fx);
    @(negedge clk);
    rst = 1'b1;
    {s_an, s_ax, s_fx} = {an, ax, fx};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // Expected {speed, duplex} for common abilities under a speed ceiling
  function automatic logic [2:0] best(input logic [15:0] c, input logic g, input int lim);
    if (g && lim == 2) return 3'b101;
    if (lim >= 1 && c[AD_100FD]) return 3'b011;
    if (lim >= 1 && c[AD_100HD]) return 3'b010;
    return {2'b00, c[AD_10FD]};
  endfunction
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {we, re, addr, wd, s_an, s_ax, s_fx, p_ok, p_gig, p_x, p_mode, p_dly, p_page} = '0;
    fail_count = 0;
    compares = 0;
    void'($urandom(10));
    do_reset(1'b0, 1'b0, 1'b0);
    foreach (ra[i]) begin
      rdr(ra[i], v);
      check(v, rv[i], "reset value");
    end
    rdr(REG_BASIC_STATUS, adv);
    wr(REG_BASIC_STATUS, ~adv);
    rdr(REG_BASIC_STATUS, v);
    check(v, adv, "status write");
    for (int k = 0; k < 3; k++) begin
      adv = (k == 1 ? 16'h00A1 : AD_RESET) | (16'($urandom) & 16'h0C00);
      p_page = AD_RESET | (16'($urandom) & 16'h0C00);
      p_mode = 3'h0;
      p_ok = 1'b1;
      p_dly = 4'($urandom % 8);
      wr(REG_ADVERTISE, adv);
      wr(REG_BASIC_CONTROL, 16'h1340);
      // Break is already under way when the write task returns
      n = int'(halt === 1'b1);
      repeat (40) begin
        @(negedge clk);
        n += (halt === 1'b1);
      end
      check(16'(n), 16'(BRK), "break length");
      check({15'h0, flp}, 16'h0001, "pulses resume");
      v = (adv[AD_10FD] | adv[AD_100FD]) ? {14'h0, adv[11:10]} : 16'h0000;
      check({14'h0, txp[11:10]}, v, "pause sent");
      p_mode = 3'h1;
      wait_hi(2);
      check({13'h0, spd, fd}, {13'h0, best(adv & p_page, 1'b0, 1)}, "resolve");
      rdr(REG_BASIC_STATUS, v);
      check(v & 16'h0024, 16'h0024, "status");
      rdr(REG_PARTNER, v);
      check(v, p_page, "partner page");
      rdr(REG_EXPANSION, v);
      check({15'h0, v[EX_LP_ABLE]}, 16'h0001, "partner able");
    end
    p_ok = 1'b0;
    wait_hi(3);
    check({15'h0, halt}, 16'h0001, "link loss");
    p_mode = 3'h0;
    np = 16'($urandom) & 16'h7FFF;
    p_page = AD_RESET | 16'h8000;
    wr(REG_NP_TRANSMIT, np);
    wr(REG_ADVERTISE, p_page);
    wr(REG_BASIC_CONTROL, 16'h1340);
    wait_hi(3);
    wait_hi(1);
    p_mode = 3'h1;
    for (int i = 0; i < 60 && txp !== np; i++) @(negedge clk);
    check(txp, np, "next page");
    wr(REG_ADVERTISE, AD_RESET);
    p_ok = 1'b1;
    for (int k = 2; k < 5; k++) begin
      p_mode = 3'h0;
      wr(REG_BASIC_CONTROL, 16'h1340);
      wait_hi(3);
      wait_hi(1);
      p_mode = 3'(k);
      if (k == 4) break;
      wait_hi(2);
      check({13'h0, spd, fd}, (k == 3) ? 16'h0002 : 16'h0000, "legacy speed");
      rdr(REG_PARTNER, v);
      check(v & 16'h00BF, (k == 3) ? 16'h0081 : 16'h0021, "legacy page");
      rdr(REG_EXPANSION, v);
      check({15'h0, v[EX_LP_ABLE]}, 16'h0000, "legacy done");
    end
    repeat (20) @(negedge clk);
    p_mode = 3'h0;
    repeat (3) @(negedge clk);
    rdr(REG_EXPANSION, v);
    check({15'h0, v[EX_PD_FAULT]}, 16'h0001, "fault set");
    rdr(REG_EXPANSION, v);
    check({15'h0, v[EX_PD_FAULT]}, 16'h0000, "fault clear");
    wr(REG_PHY_CONTROL, 16'h0020);
    wr(REG_BASIC_CONTROL, 16'h1340);
    wait_hi(3);
    wait_hi(1);
    check({15'h0, sab}, 16'h0001, "forced cross");
    wr(REG_BASIC_CONTROL, 16'h0000);
    wr(REG_PHY_CONTROL, PC_RESET);
    for (int k = 0; k < 4; k++) begin
      p_x = k[0];
      repeat (4) @(negedge clk);
      check({15'h0, sab}, {15'h0, p_x}, "forced speed cross");
    end
    wr(REG_BASIC_CONTROL, 16'h1000);
    wait_hi(3);
    check({15'h0, halt}, 16'h0001, "re-enable");
    {p_gig, p_x, p_page, p_mode} = {2'b11, AD_RESET, 3'h1};
    for (int e = 0; e < 2; e++) begin
      wr(REG_PHY_CONTROL, (e == 1) ? 16'h2840 : 16'h2040);
      wr(REG_BASIC_CONTROL, 16'h1340);
      cap = spd_1000;
      cnt = 0;
      foreach (plan[i]) begin
        p_ok = 1'b0;
        wait_hi(3);
        wait_hi(1);
        p_ok = plan[i][0];
        wait_hi(0);
        v = 16'(best(AD_RESET, 1'b1, cap) >> 1);
        check(16'(spd), v, "downshift");
        check({15'h0, scd}, {15'h0, cap == spd_1000}, "pair cd");
        if (plan[i] == 1) begin
          cnt = 0;
          wait_hi(2);
        end else if (e == 1) begin
          cnt++;
          if (cnt == 2) begin
            cnt = 0;
            cap = (cap == spd_1000) ? spd_100 : spd_10;
          end
        end
      end
    end
    p_x = 1'b0;
    do_reset(1'b1, 1'b1, 1'b1);
    rdr(REG_PHY_CONTROL, v);
    check({14'h0, v[6:5]}, 16'h0001, "cross straps");
    wr(REG_BASIC_CONTROL, 16'h1000);
    rdr(REG_BASIC_CONTROL, v);
    check({15'h0, v[BC_AN_EN]}, 16'h0000, "locked off");
    check({14'h0, flp, sab}, 16'h0001, "off and crossed");
    print_verdict();
  end
endmodule
